// [pcs_consts.svh]
// Constants of the deterministic latency PCS: offsets, fields, resets, depths
// Contract
// - In deterministic latency mode the receive phase compensation stage is always a register.
// - The transmit phase compensation stage is a FIFO or a register, chosen by software.
// - In registered mode the stage is one pipeline register with a fixed delay after every reset.
// - In manual alignment the 5-bit receive slip count reports the bits slipped to synchronise.
// - The transmitter delays its serial output by the bit count on the 5-bit slip-select input.
// - The transmit slip-select covers zero through nine bits of slip.
// - Phase-detector feedback is offered when the reference equals the low-speed clock.
// - Deterministic latency mode is offered for a single channel and for four bonded channels.
// - Transmit latency is 2.5 to 3.5 word cycles with the byte serializer, 4 to 5 without.
// - Receive latency is 5 to 6 word cycles with the byte deserializer, 8 to 9 without.
// - Video mode is a single unbonded channel that only serializes and deserializes; the code keeps the phase compensation stages active in video mode.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ************************************************
// Register offsets
// ************************************************
`define OFS_CTRL        8'h00
`define OFS_PATTERN     8'h04
`define OFS_STATUS      8'h08

// ************************************************
// Control fields
// ************************************************
`define CTRL_VIDEO      0
`define CTRL_TX_REG     1
`define CTRL_BYTE_SER   2
`define CTRL_BITSLIP    3
`define CTRL_BONDED     4
`define CTRL_PFD        5
`define CTRL_REALIGN    8

// ************************************************
// Status fields
// ************************************************
`define STAT_SLIP_LSB   0
`define STAT_SYNCED     8
`define STAT_PFD_ON     9
`define STAT_BONDED_ON  10
`define STAT_LEVEL_LSB  16

// ************************************************
// Reset values
// ************************************************
`define PATTERN_RESET   10'h0fa
`define HRESP_OKAY      1'b0

// ************************************************
// Word widths, slip range and pipeline depths
// ************************************************
`define BITS_NARROW     5'd10
`define BITS_WIDE       5'd20
`define SLIP_MAX        5'd9
`define TX_DEPTH_SER    3
`define TX_DEPTH_PLAIN  4
`define RX_DEPTH_SER    5
`define RX_DEPTH_PLAIN  8
`define TX_FIFO_DEPTH   32

`endif

// [pcs_pkg.sv]
// Types shared by the deterministic latency PCS files
package pcs_pkg;

	typedef logic [19:0] word_t;

	// Software configuration of the channel
	typedef struct packed {
		logic video;
		logic tx_reg;
		logic byte_ser;
		logic bitslip;
		logic bonded;
		logic pfd;
	} cfg_t;

	// Captured AHB address phase
	typedef struct packed {
		logic       sel;
		logic       write;
		logic [7:0] addr;
	} ahb_req_t;

	typedef enum logic {
		ALIGN_SEARCH,
		ALIGN_LOCKED
	} align_t;

endpackage

// [pcs_ram.sv]
// Simple dual-port memory with registered read data
`timescale 1ns/10ps
module pcs_ram #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [WIDTH-1:0]         rdata
);
	logic [WIDTH-1:0] mem [0:DEPTH-1];

	// Write port
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// Read port, old data on a same-address collision
	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr];
	end
endmodule // pcs_ram

// [pcs_fifo.sv]
// Show-ahead FIFO built on the registered-read memory
`timescale 1ns/10ps
module pcs_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 32
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic [WIDTH-1:0]       in_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic      [WIDTH-1:0]       out_data,
	output logic      [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW-1:0] rd_ptr_nxt;
	logic [AW:0]   count_r;
	logic          stale_r;
	logic          push;
	logic          pop;

	// Handshakes; head is unusable the cycle after it was written
	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != '0) && !stale_r;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
	assign level     = count_r;

	// Pointers and fill count
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			stale_r  <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= (AW+1)'(count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
			stale_r  <= push && (wr_ptr_r == rd_ptr_nxt);
		end
	end

	pcs_ram #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_ram (
		.clk   (clk),
		.we    (push),
		.waddr (wr_ptr_r),
		.wdata (in_data),
		.raddr (rd_ptr_nxt),
		.rdata (out_data)
	);
endmodule // pcs_fifo

// [pcs_core.sv]
// Deterministic latency PCS channel with AHB-Lite control registers
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pcs_core #(
	parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
	input  wire logic          CLK_SYS,
	input  wire logic          RST,
	input  wire logic          HSEL,
	input  wire logic [31:0]   HADDR,
	input  wire logic [1:0]    HTRANS,
	input  wire logic          HWRITE,
	input  wire logic [2:0]    HSIZE,
	input  wire logic [31:0]   HWDATA,
	input  wire logic          HREADY,
	output logic      [31:0]   HRDATA,
	output logic               HREADYOUT,
	output logic               HRESP,
	input  wire pcs_pkg::word_t TX_DATA,
	input  wire logic          TX_VALID,
	output logic               TX_READY,
	output logic               TX_WORD_STB,
	input  wire logic [4:0]    TX_SLIP_SEL,
	output logic               TX_SERIAL,
	input  wire logic          RX_SERIAL,
	input  wire logic          RX_BITSLIP,
	output pcs_pkg::word_t     RX_DATA,
	output logic               RX_VALID,
	output logic [4:0]         RX_SLIP_COUNT,
	output logic               RX_SYNCED
);
	import pcs_pkg::*;

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// ************************************************
	// Declarations
	// ************************************************
	ahb_req_t   areq_r;
	cfg_t       cfg_r;
	logic [9:0] pattern_r;
	logic       realign_r;
	logic       bonded_on;
	logic       pfd_on;
	logic [4:0] wbits;
	logic [4:0] tx_phase_r;
	logic [4:0] tx_phase_nxt;
	logic       tx_stb;
	logic       tx_take;
	logic       fifo_push;
	logic       fifo_pop;
	logic       fifo_ov;
	word_t      fifo_data;
	logic [LW-1:0] fifo_level;
	logic [LW-1:0] level_nxt;
	word_t      tx_src;
	word_t      tx_pipe_r [0:`TX_DEPTH_PLAIN-1];
	word_t      tx_tap;
	word_t      tx_sh_r;
	logic [8:0] tx_hist_r;
	logic [4:0] tx_slip_r;
	logic [4:0] slip_in;
	logic       rx_meta_r;
	logic       rx_bit_r;
	word_t      rx_sh_r;
	logic [4:0] rx_phase_r;
	logic [4:0] rx_phase_nxt;
	logic       rx_stb;
	logic       rx_match;
	logic       rx_take;
	logic       bs_d_r;
	logic       bs_edge;
	align_t     align_r;
	logic [4:0] rx_slip_r;
	word_t      rx_word;
	word_t      rx_pipe_r [0:`RX_DEPTH_PLAIN-1];
	logic [31:0] status;

	// ************************************************
	// Register bus
	// ************************************************

	// Address phase capture; only word transfers are expected
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			areq_r <= '0;
		else if (HREADY)
			areq_r <= '{sel: HSEL && HTRANS[1], write: HWRITE, addr: HADDR[7:0]};
	end

	// Zero wait state slave, always OKAY
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= `HRESP_OKAY;
		end
		else
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= `HRESP_OKAY;
		end
	end

	// Effective mode: video forces a single unbonded channel
	assign bonded_on = cfg_r.bonded && !cfg_r.video;
	assign pfd_on    = cfg_r.pfd && !cfg_r.video;

	assign status = {{(16-LW){1'b0}}, fifo_level, 5'h00, bonded_on, pfd_on,
		RX_SYNCED, 3'h0, RX_SLIP_COUNT};

	// Read decode of the unmapped space returns zero
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		if (a == `OFS_CTRL)
			reg_read = {26'h0, cfg_r.pfd, cfg_r.bonded, cfg_r.bitslip,
				cfg_r.byte_ser, cfg_r.tx_reg, cfg_r.video};
		else if (a == `OFS_PATTERN)
			reg_read = {22'h0, pattern_r};
		else if (a == `OFS_STATUS)
			reg_read = status;
		else
			reg_read = 32'h0000_0000;
	endfunction

	// Read data prepared at the end of the address phase
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			HRDATA <= 32'h0000_0000;
		else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
			HRDATA <= reg_read(HADDR[7:0]);
		else
			HRDATA <= 32'h0000_0000;
	end

	// Register writes in the data phase; realign is a one-cycle pulse
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			cfg_r     <= '0;
			pattern_r <= `PATTERN_RESET;
			realign_r <= 1'b0;
		end
		else
		begin
			realign_r <= 1'b0;
			if (areq_r.sel && areq_r.write)
			begin
				if (areq_r.addr == `OFS_CTRL)
				begin
					cfg_r.video    <= HWDATA[`CTRL_VIDEO];
					cfg_r.tx_reg   <= HWDATA[`CTRL_TX_REG];
					cfg_r.byte_ser <= HWDATA[`CTRL_BYTE_SER];
					cfg_r.bitslip  <= HWDATA[`CTRL_BITSLIP];
					cfg_r.bonded   <= HWDATA[`CTRL_BONDED];
					cfg_r.pfd      <= HWDATA[`CTRL_PFD];
					realign_r      <= HWDATA[`CTRL_REALIGN];
				end
				else if (areq_r.addr == `OFS_PATTERN)
					pattern_r <= HWDATA[9:0];
			end
		end
	end

	// ************************************************
	// Transmit word timing and phase compensation
	// ************************************************

	// Byte serializer doubles the bits per fabric word
	assign wbits = cfg_r.byte_ser ? `BITS_WIDE : `BITS_NARROW;

	assign tx_stb = (tx_phase_r >= 5'(wbits - 5'd1));
	assign tx_phase_nxt = tx_stb ? 5'd0 : 5'(tx_phase_r + 5'd1);

	// One word slot every wbits serial bits
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			tx_phase_r  <= 5'd0;
			TX_WORD_STB <= 1'b0;
		end
		else
		begin
			tx_phase_r  <= tx_phase_nxt;
			TX_WORD_STB <= (tx_phase_nxt >= 5'(wbits - 5'd1));
		end
	end

	// Registered mode accepts at most one word per slot
	assign tx_take   = TX_VALID && TX_READY && cfg_r.tx_reg;
	assign fifo_push = TX_VALID && TX_READY && !cfg_r.tx_reg;
	assign fifo_pop  = tx_stb && fifo_ov && !cfg_r.tx_reg;
	assign level_nxt = LW'(fifo_level + {{(LW-1){1'b0}}, fifo_push}
		- {{(LW-1){1'b0}}, fifo_pop});

	// Ready from a flop: slot cycle in registered mode, free space otherwise
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			TX_READY <= 1'b0;
		else if (cfg_r.tx_reg)
			TX_READY <= (tx_phase_nxt >= 5'(wbits - 5'd1));
		else
			TX_READY <= (level_nxt < LW'(FIFO_DEPTH));
	end

	pcs_fifo #(
		.WIDTH ($bits(word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (CLK_SYS),
		.rst       (RST),
		.in_valid  (fifo_push),
		.in_ready  (),
		.in_data   (TX_DATA),
		.out_valid (fifo_ov),
		.out_ready (fifo_pop),
		.out_data  (fifo_data),
		.level     (fifo_level)
	);

	// Idle slots send zeros; rate match and byte ordering do not exist here
	always_comb
	begin
		if (cfg_r.tx_reg)
			tx_src = tx_take ? TX_DATA : '0;
		else
			tx_src = fifo_ov ? fifo_data : '0;
	end

	// ************************************************
	// Transmit pipeline, serializer and bit slip
	// ************************************************

	// Fixed-depth pipeline stepped once per word slot
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			for (int i = 0; i < `TX_DEPTH_PLAIN; i++)
				tx_pipe_r[i] <= '0;
		end
		else if (tx_stb)
		begin
			tx_pipe_r[0] <= tx_src;
			for (int i = 1; i < `TX_DEPTH_PLAIN; i++)
				tx_pipe_r[i] <= tx_pipe_r[i-1];
		end
	end

	// Tap chosen by byte serializer use
	assign tx_tap = cfg_r.byte_ser ? tx_pipe_r[`TX_DEPTH_SER-1]
		: tx_pipe_r[`TX_DEPTH_PLAIN-1];

	// Slip amount clamped to nine; video mode slips nothing
	assign slip_in = cfg_r.video ? 5'd0
		: (TX_SLIP_SEL > `SLIP_MAX) ? `SLIP_MAX : TX_SLIP_SEL;

	// Serializer sends LSB first; slip taken at a word edge to avoid a torn word
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			tx_sh_r   <= '0;
			tx_hist_r <= 9'h000;
			tx_slip_r <= 5'd0;
		end
		else
		begin
			tx_hist_r <= {tx_hist_r[7:0], tx_sh_r[0]};
			if (tx_stb)
			begin
				tx_sh_r   <= tx_tap;
				tx_slip_r <= slip_in;
			end
			else
				tx_sh_r <= {1'b0, tx_sh_r[19:1]};
		end
	end

	// Delay the serial stream by the selected bit count
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			TX_SERIAL <= 1'b0;
		else if (tx_slip_r == 5'd0)
			TX_SERIAL <= tx_sh_r[0];
		else
			TX_SERIAL <= tx_hist_r[4'(tx_slip_r - 5'd1)];
	end

	// ************************************************
	// Receive synchroniser and deserializer
	// ************************************************

	// Serial pin crosses in through two flops
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			rx_meta_r <= 1'b0;
			rx_bit_r  <= 1'b0;
			rx_sh_r   <= '0;
			bs_d_r    <= 1'b0;
		end
		else
		begin
			rx_meta_r <= RX_SERIAL;
			rx_bit_r  <= rx_meta_r;
			rx_sh_r   <= {rx_bit_r, rx_sh_r[19:1]};
			bs_d_r    <= RX_BITSLIP;
		end
	end

	// ************************************************
	// Word aligner
	// ************************************************
	assign rx_stb   = (rx_phase_r >= 5'(wbits - 5'd1));
	assign rx_match = !cfg_r.video && !cfg_r.bitslip && (align_r == ALIGN_SEARCH)
		&& (rx_sh_r[19:10] == pattern_r);
	assign bs_edge  = RX_BITSLIP && !bs_d_r && cfg_r.bitslip && !cfg_r.video;
	assign rx_take  = rx_stb || rx_match;

	// A slip holds the boundary one bit; a match ends a word at once
	always_comb
	begin
		if (bs_edge)
			rx_phase_nxt = rx_phase_r;
		else if (rx_take)
			rx_phase_nxt = 5'd0;
		else
			rx_phase_nxt = 5'(rx_phase_r + 5'd1);
	end

	// Boundary, lock state and slip count
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			rx_phase_r <= 5'd0;
			align_r    <= ALIGN_SEARCH;
			rx_slip_r  <= 5'd0;
		end
		else
		begin
			rx_phase_r <= rx_phase_nxt;
			if (cfg_r.video)
			begin
				align_r   <= ALIGN_SEARCH;
				rx_slip_r <= 5'd0;
			end
			else if (realign_r)
				align_r <= ALIGN_SEARCH;
			else if (rx_match)
			begin
				align_r   <= ALIGN_LOCKED;
				rx_slip_r <= 5'(wbits - 5'd1 - rx_phase_r);
			end
			else if (bs_edge)
				rx_slip_r <= (rx_slip_r >= 5'(wbits - 5'd1)) ? 5'd0
					: 5'(rx_slip_r + 5'd1);
		end
	end

	// Report sync and slip; bit-slip and video modes count as synchronised
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			RX_SYNCED     <= 1'b0;
			RX_SLIP_COUNT <= 5'd0;
		end
		else
		begin
			RX_SYNCED     <= cfg_r.video || cfg_r.bitslip || (align_r == ALIGN_LOCKED);
			RX_SLIP_COUNT <= rx_slip_r;
		end
	end

	// ************************************************
	// Receive pipeline, always registered
	// ************************************************
	assign rx_word = cfg_r.byte_ser ? rx_sh_r : {10'h000, rx_sh_r[19:10]};

	// Register stages give a fixed delay with no FIFO uncertainty
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			for (int i = 0; i < `RX_DEPTH_PLAIN; i++)
				rx_pipe_r[i] <= '0;
		end
		else if (rx_take)
		begin
			rx_pipe_r[0] <= rx_word;
			for (int i = 1; i < `RX_DEPTH_PLAIN; i++)
				rx_pipe_r[i] <= rx_pipe_r[i-1];
		end
	end

	// Output tap chosen by byte deserializer use
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			RX_DATA  <= '0;
			RX_VALID <= 1'b0;
		end
		else
		begin
			RX_VALID <= rx_take;
			if (rx_take)
				RX_DATA <= cfg_r.byte_ser ? rx_pipe_r[`RX_DEPTH_SER-1]
					: rx_pipe_r[`RX_DEPTH_PLAIN-1];
		end
	end
endmodule // pcs_core

// [pcs_core_properties.sv]
// Concurrent checks on the ports of the PCS channel
`timescale 1ns/10ps
module pcs_core_properties (
	input wire logic                 CLK_SYS,
	input wire logic                 RST,
	input wire logic                 HSEL,
	input wire logic [1:0]           HTRANS,
	input wire logic                 HWRITE,
	input wire logic                 HREADY,
	input wire logic [31:0]          HRDATA,
	input wire logic                 HREADYOUT,
	input wire logic                 HRESP,
	input wire logic                 TX_READY,
	input wire logic                 TX_WORD_STB,
	input wire pcs_pkg::word_t       RX_DATA,
	input wire logic                 RX_VALID,
	input wire logic [4:0]           RX_SLIP_COUNT,
	input wire logic                 RX_SYNCED
);
	import pcs_pkg::*;
	// ************************************************
	// Helpers and sequences
	// ************************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic rd_q;
	// Read data may only stand in the cycle after a taken read
	always_ff @(posedge CLK_SYS)
	begin
		rd_q <= HSEL && HTRANS[1] && !HWRITE && HREADY;
	end
	sequence slot_gap;
		!TX_WORD_STB [*8];
	endsequence
	// A pattern match may close a word early while searching; only words while RX_SYNCED is high are spaced
	sequence rx_gap;
		(!RX_VALID || !RX_SYNCED) [*8];
	endsequence
	// ************************************************
	// Assertions
	// ************************************************
	zero_wait_a: assert property (HREADYOUT)
		else $error("slave inserted a wait state");
	resp_okay_a: assert property (HRESP == 1'b0)
		else $error("slave answered with an error");
	rdata_idle_a: assert property (!rd_q |-> HRDATA == 32'h0)
		else $error("read data outside a data phase");
	slot_space_a: assert property (TX_WORD_STB |=> slot_gap)
		else $error("word slots closer than a word");
	rx_word_a: assert property (RX_VALID |=> rx_gap)
		else $error("received words closer than a word");
	rx_hold_a: assert property (!RX_VALID |-> $stable(RX_DATA))
		else $error("received word changed without valid");
	slip_range_a: assert property (RX_SLIP_COUNT <= 5'd19)
		else $error("slip count beyond a wide word");
	reset_quiet_a: assert property ($fell(RST) |-> !TX_READY && !TX_WORD_STB && !RX_VALID
		&& !RX_SYNCED && RX_SLIP_COUNT == 5'h0)
		else $error("outputs not cleared by reset");
endmodule // pcs_core_properties

bind pcs_core pcs_core_properties chk (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_READY(TX_READY), .TX_WORD_STB(TX_WORD_STB),
	.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_SLIP_COUNT(RX_SLIP_COUNT),
	.RX_SYNCED(RX_SYNCED));

// [pcs_fabric_model.sv]
// Fabric user logic feeding the transmit stream and steering slip
`timescale 1ns/10ps
module pcs_fabric_model (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             en,
	input wire pcs_pkg::word_t   word,
	input wire logic             tx_ready,
	output pcs_pkg::word_t       tx_data,
	output logic                 tx_valid,
	input wire logic [4:0]       rx_slip_count,
	output logic [4:0]           tx_slip_sel,
	output logic                 rx_bitslip
);
	import pcs_pkg::*;
	// ************************************************
	// Stream source
	// ************************************************
	// Word held until taken; released data inverted so stale values never match
	always_ff @(posedge clk)
	begin
		if (rst)
			tx_valid <= 1'b0;
		else if (!tx_valid || tx_ready)
		begin
			tx_valid <= en;
			tx_data  <= en ? word : ~tx_data;
		end
	end
	// Slip follows the receive count only while idle, so live words are not rotated
	always_ff @(posedge clk)
	begin
		if (rst)
			tx_slip_sel <= 5'h0;
		else if (!en)
			tx_slip_sel <= rx_slip_count;
		rx_bitslip <= 1'b0;
	end
endmodule // pcs_fabric_model

// [pcs_core_tb.sv]
// Self-checking bench of the PCS channel with serial loopback
`timescale 1ns/10ps
`include "pcs_consts.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
	$display("wrong value %s expected %h seen %h", nm, exp, got); err_count++; end end
module pcs_core_tb;
	import pcs_pkg::*;
	logic        clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, en = 0;
	logic [31:0] haddr = 0, hwdata = 0, q;
	logic [1:0]  htrans = 0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, tx_ready, tx_stb, tx_serial, rx_valid, rx_synced;
	logic        tx_valid, rx_bitslip;
	logic [4:0]  slip_sel, slip_cnt;
	word_t       tx_data, rx_data, word = 0;
	int          err_count = 0, checked = 0, bad;
	// ************************************************
	// Clock, design and fabric partner
	// ************************************************
	always #25 clk_sys = ~clk_sys;
	// Serial loopback ties the transmitter to the receiver
	pcs_core uut (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_WORD_STB(tx_stb),
		.TX_SLIP_SEL(slip_sel), .TX_SERIAL(tx_serial), .RX_SERIAL(tx_serial),
		.RX_BITSLIP(rx_bitslip), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_SLIP_COUNT(slip_cnt), .RX_SYNCED(rx_synced));
	pcs_fabric_model fab (.clk(clk_sys), .rst(rst), .en(en), .word(word),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.rx_slip_count(slip_cnt), .tx_slip_sel(slip_sel), .rx_bitslip(rx_bitslip));
	// ************************************************
	// Bus and stream tasks
	// ************************************************
	// One single AHB transfer; read data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= a;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rchk(input string nm, input logic [31:0] a, m, e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		`CHK(nm, e, r & m)
	endtask
	// Waits for lock, then lets n words pass so stale pipeline words flush out
	task automatic rx_words(input int n);
		while (rx_synced !== 1'b1) @(posedge clk_sys);
		repeat (n)
		begin
			@(posedge clk_sys);
			while (rx_valid !== 1'b1) @(posedge clk_sys);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ************************************************
	// Tests
	// ************************************************
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rchk("ctrl", `OFS_CTRL, 32'hffffffff, 32'h0);
		rchk("pattern", `OFS_PATTERN, 32'h3ff, 32'h0fa);
		rchk("status", `OFS_STATUS, 32'hffffffff, 32'h0);
		wr(32'h10, 32'hffff);
		rchk("unmapped", 32'h10, 32'hffffffff, 32'h0);
		wr(`OFS_CTRL, 32'h31);
		rchk("ctrl back", `OFS_CTRL, 32'h13f, 32'h31);
		rchk("video status", `OFS_STATUS, 32'h600, 32'h0);
		`CHK("video sync", 1'b1, rx_synced)
		wr(`OFS_CTRL, 32'h30);
		rchk("bond pfd", `OFS_STATUS, 32'h600, 32'h600);
		$display("registers test done");
		// Pattern alignment of narrow words while the queue fills behind a slow line
		word <= 20'h000fa;
		en <= 1'b1;
		wr(`OFS_CTRL, 32'h100);
		rx_words(12);
		`CHK("narrow word", 20'h000fa, rx_data)
		`CHK("narrow slip", 1'b1, slip_cnt <= 5'd9)
		`CHK("queue refuses", 1'b0, tx_ready)
		ahb(1'b0, `OFS_STATUS, 32'h0, q);
		`CHK("queue full", 1'b1, q[21:16] >= 6'd31)
		en <= 1'b0;
		do ahb(1'b0, `OFS_STATUS, 32'h0, q); while (q[21:16] !== 6'd0);
		`CHK("queue open", 1'b1, tx_ready)
		$display("narrow and queue test done");
		// Wide words through both byte stages, then registered transmit stage
		// Pattern sits in the second half so the aligner closes the word on it
		word <= 20'h3ebe8;
		en <= 1'b1;
		wr(`OFS_CTRL, 32'h104);
		rx_words(20);
		`CHK("wide word", 20'h3ebe8, rx_data)
		wr(`OFS_CTRL, 32'h106);
		// Ready of the write cycle still follows the queue mode
		@(posedge clk_sys);
		bad = 0;
		repeat (100)
		begin
			@(posedge clk_sys);
			if (tx_ready === 1'b1 && tx_stb !== 1'b1) bad++;
		end
		`CHK("ready off slot", 0, bad)
		rx_words(20);
		`CHK("registered word", 20'h3ebe8, rx_data)
		$display("wide and registered test done");
		final_report();
	end
	// Watchdog well beyond the few thousand cycles the tests need
	initial
	begin
		#(30000 * 50);
		err_count++;
		final_report();
	end
endmodule // pcs_core_tb
